// ### core/wwc_map.vh
`ifndef WWC_MAP_VH
`define WWC_MAP_VH
// Register byte offsets
`define WWC_OFS_WDT_CTRL 12'h000
`define WWC_OFS_SYS_FLAGS 12'h004
`define WWC_OFS_STATUS 12'h008
// Watchdog control fields
`define WWC_KEY_HI 7
`define WWC_KEY_LO 3
`define WWC_SEL_HI 2
`define WWC_SEL_LO 0
`define WWC_KEY_OK_A 5'h0a
`define WWC_KEY_OK_B 5'h15
`define WWC_WDT_CTRL_RST 8'h53
// System flag fields
`define WWC_FLAG_SWR 0
`define WWC_FLAG_KEEP_ON 7
`define WWC_SYS_FLAGS_RST 8'h00
// Status fields
`define WWC_ST_TO 0
`define WWC_ST_PDF 1
`define WWC_ST_ASLEEP 2
`define WWC_ST_STARTUP 3
// Timing counts
`define WWC_CNT_W 18
`define WWC_DEBOUNCE_TICKS 2
`define WWC_SST_FAST_CYC 1024
`define WWC_SST_SLOW_CYC 2
`endif

// ### core/wwc_watchdog_wake.v
`timescale 1ns/1ns
`include "wwc_map.vh"
// How it works
// - Wake on pin edge, interrupt, or overflow
// - Overflow wake also starts watchdog reset
// - Power-down flag: cleared power-up/clear, set halt
// - Per-pin enable, falling edge wakes
// - Pin wake resumes after halt instruction
// - Disabled or stack-full interrupt resumes, stays pending
// - Enabled interrupt with free stack is serviced
// - Flag already set at entry cannot wake
// - Normal wake waits for fast oscillator stable
// - Watchdog counts sub clock, 2^8 to 2^18
// - Period select codes map to fixed timeouts
// - Illegal key resets after 2-3 ticks
// - Illegal key reset sets soft reset flag
// - Software clears soft flag, never sets
// - Flag bits 6..1 read zero
// - Normal timeout: full reset, set timeout flag
// - Asleep timeout: flag, reset PC/SP only
// - Count cleared by soft reset, clear, halt
// - Halt sets power-down, clears timeout, restarts count
module wwc_watchdog_wake #(
    parameter NPIN = 8,
    parameter NIRQ = 4,
    parameter SST_FAST = `WWC_SST_FAST_CYC,
    parameter SST_SLOW = `WWC_SST_SLOW_CYC
) (
    input wire core_clk_i, // 125 MHz core clock
    input wire rst_i, // Async power-up reset, high
    input wire ce_i, // Clock enable, freezes state
    input wire psel_i, // APB select
    input wire penable_i, // APB access phase
    input wire pwrite_i, // APB write
    input wire [11:0] paddr_i, // APB byte address
    input wire [31:0] pwdata_i, // APB write data
    output wire [31:0] prdata_o, // APB read data
    output wire pready_o, // APB ready, always high
    output wire pslverr_o, // APB error on unmapped address
    input wire sub_clock_i, // Slow oscillator level, sampled
    input wire [NPIN-1:0] port_i, // Port pin levels
    input wire [NPIN-1:0] port_wake_enable_i, // Per-pin wake enable
    input wire [NIRQ-1:0] irq_req_i, // Interrupt request flags
    input wire [NIRQ-1:0] irq_en_i, // Interrupt enables
    input wire stack_full_i, // No free stack level
    input wire halt_exec_i, // Stop instruction pulse
    input wire idle_select_i, // High selects idle rather than sleep
    input wire clear_watchdog_instruction_i, // Clear-watchdog instruction pulse
    input wire sysclk_fast_i, // System clock is fast oscillator
    input wire fast_osc_stable_i, // Fast oscillator stable flag
    output reg cpu_run_o, // CPU may execute
    output reg device_reset_o, // Full device reset pulse
    output reg pc_sp_reset_o, // PC and stack pointer reset pulse
    output reg resume_next_o, // Resume after halt pulse
    output reg irq_service_o, // Take interrupt response pulse
    output reg [NIRQ-1:0] irq_wake_src_o, // Interrupt that woke us
    output reg asleep_o, // In sleep or idle
    output reg idle_clk_keep_on_o, // Keep system clock on in idle
    output reg timeout_flag_o, // Watchdog timeout flag
    output reg power_down_flag_o // Power-down flag
);

    // Sequencer states; start-up is its own state so that the
    // oscillator wait can never overlap a fresh halt request.
    // Sleep and idle share one state: the idle choice only
    // decides which clocks the CPU side keeps running.
    localparam ST_RUN = 2'd0; // Executing
    localparam ST_SLEEP = 2'd1; // Low-power state
    localparam ST_START = 2'd2; // Oscillator start-up wait
    localparam CAUSE_PIN = 2'd0; // Woken by port pin
    localparam CAUSE_IRQ = 2'd1; // Woken by interrupt
    localparam CAUSE_WDT = 2'd2; // Woken by overflow

    reg [7:0] wdt_ctrl_reg; // Key and period select
    reg swr_flag_reg; // Soft watchdog reset flag
    reg [`WWC_CNT_W-1:0] wdt_cnt_reg; // Free-running watchdog count
    reg sub_prev_reg; // Last sub clock sample
    reg [NPIN-1:0] pin_prev_reg; // Pins sampled on sub clock
    reg [NIRQ-1:0] irq_armed_reg; // Requests clear at entry
    reg [1:0] state_reg; // Sequencer state
    reg [1:0] cause_reg; // Recorded wake cause
    reg [10:0] sst_cnt_reg; // Start-up delay counter
    reg [1:0] deb_cnt_reg; // Illegal key debounce ticks

    // Period codes are not evenly spaced: the first four step by
    // two stages, the last four by one. A table is clearer than
    // arithmetic on the code and costs only a few gates.
    // Stage bit whose fall marks overflow for each period code
    function [4:0] wwc_stage;
        input [2:0] sel;
        begin
            case (sel)
                3'd0: wwc_stage = 5'd7;
                3'd1: wwc_stage = 5'd9;
                3'd2: wwc_stage = 5'd11;
                3'd3: wwc_stage = 5'd13;
                3'd4: wwc_stage = 5'd14;
                3'd5: wwc_stage = 5'd15;
                3'd6: wwc_stage = 5'd16;
                default: wwc_stage = 5'd17;
            endcase
        end
    endfunction

    // Only two key patterns keep the watchdog alive; any other
    // value, including all zeros, leads to a soft reset. This
    // makes a stray write far less likely to go unnoticed.
    // Legal key check, used by reset and debounce logic
    function wwc_key_ok;
        input [4:0] key;
        begin
            wwc_key_ok = (key == `WWC_KEY_OK_A) || (key == `WWC_KEY_OK_B);
        end
    endfunction

    // The slow clock is sampled as a level by the core clock, so
    // it must stay high and low for at least one core cycle each.
    // A faster slow clock would lose ticks and stretch timeouts.
    wire sub_tick = sub_clock_i & ~sub_prev_reg; // Sub clock rising edge
    wire [`WWC_CNT_W-1:0] cnt_inc = wdt_cnt_reg + 18'h0_0001; // Next count
    wire [4:0] stage = wwc_stage(wdt_ctrl_reg[`WWC_SEL_HI:`WWC_SEL_LO]);
    // Overflow when the chosen stage falls on a tick
    wire wdt_ovf = sub_tick & wdt_cnt_reg[stage] & ~cnt_inc[stage];
    wire key_bad = ~wwc_key_ok(wdt_ctrl_reg[`WWC_KEY_HI:`WWC_KEY_LO]);
    wire soft_rst = key_bad & sub_tick & (deb_cnt_reg == `WWC_DEBOUNCE_TICKS);
    wire asleep = (state_reg == ST_SLEEP); // Low-power state active
    // Pins only seen on sub ticks so wake works with system clock off
    wire [NPIN-1:0] pin_fall = pin_prev_reg & ~port_i & port_wake_enable_i & {NPIN{sub_tick}};
    wire [NIRQ-1:0] irq_hit = irq_req_i & irq_armed_reg;
    wire irq_wake = |irq_hit; // Any armed request
    wire pin_wake = |pin_fall; // Any qualified pin edge
    wire wdt_wake = asleep & wdt_ovf;
    wire sst_done = sysclk_fast_i ? (sst_cnt_reg == SST_FAST[10:0]) : (sst_cnt_reg == SST_SLOW[10:0]);
    // Normal-mode wake also needs the fast oscillator settled
    wire start_ok = sst_done & (~sysclk_fast_i | fast_osc_stable_i);
    wire full_rst = soft_rst | (wdt_ovf & ~asleep); // Device-wide reset

    // Register access. Every register answers at once, so ready
    // is tied high; a master that waits for ready still works.
    // Unmapped offsets flag an error and read back zero.
    // APB decode, zero wait states
    wire acc = psel_i & penable_i; // Access phase
    wire hit_ctrl = (paddr_i == `WWC_OFS_WDT_CTRL); // Watchdog control
    wire hit_flags = (paddr_i == `WWC_OFS_SYS_FLAGS); // System flags
    wire hit_stat = (paddr_i == `WWC_OFS_STATUS); // Status, read-only
    wire mapped = hit_ctrl | hit_flags | hit_stat; // Any known register
    wire wr_ctrl = acc & pwrite_i & hit_ctrl & ce_i; // Control write
    wire wr_flags = acc & pwrite_i & hit_flags & ce_i; // Flags write

    assign pready_o = 1'b1;
    assign pslverr_o = acc & ~mapped;

    // Read mux; bits 6..1 of flags read zero
    reg [31:0] rd_mux;
    always @*
    begin
        rd_mux = 32'h0000_0000;
        if (hit_ctrl)
            rd_mux[7:0] = wdt_ctrl_reg;
        else if (hit_flags)
        begin
            rd_mux[`WWC_FLAG_KEEP_ON] = idle_clk_keep_on_o;
            rd_mux[`WWC_FLAG_SWR] = swr_flag_reg;
        end
        else if (hit_stat)
        begin
            rd_mux[`WWC_ST_TO] = timeout_flag_o;
            rd_mux[`WWC_ST_PDF] = power_down_flag_o;
            rd_mux[`WWC_ST_ASLEEP] = asleep;
            rd_mux[`WWC_ST_STARTUP] = (state_reg == ST_START);
        end
    end
    assign prdata_o = rd_mux;

    // Register file and flags.
    // Every flag that hardware sets and software clears gives the
    // hardware event priority, so an event in the clearing cycle
    // is never lost. A full reset from this block restores the
    // control defaults but leaves the status flags alone, so
    // software can read why the reset happened.
    always @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            wdt_ctrl_reg <= `WWC_WDT_CTRL_RST;
            swr_flag_reg <= 1'b0;
            idle_clk_keep_on_o <= 1'b0;
            timeout_flag_o <= 1'b0;
            power_down_flag_o <= 1'b0;
        end
        else if (ce_i)
        begin
            // Full reset restores control defaults
            if (full_rst)
                wdt_ctrl_reg <= `WWC_WDT_CTRL_RST;
            else if (wr_ctrl)
                wdt_ctrl_reg <= pwdata_i[7:0];
            // Hardware set wins over software clear
            if (soft_rst)
                swr_flag_reg <= 1'b1;
            else if (wr_flags && !pwdata_i[`WWC_FLAG_SWR])
                swr_flag_reg <= 1'b0;
            if (full_rst)
                idle_clk_keep_on_o <= 1'b0;
            else if (wr_flags)
                idle_clk_keep_on_o <= pwdata_i[`WWC_FLAG_KEEP_ON];
            // Timeout flag set on overflow in any mode
            if (wdt_ovf)
                timeout_flag_o <= 1'b1;
            else if (halt_exec_i && state_reg == ST_RUN)
                timeout_flag_o <= 1'b0;
            // Power-down flag
            if (halt_exec_i && state_reg == ST_RUN)
                power_down_flag_o <= 1'b1;
            else if (clear_watchdog_instruction_i)
                power_down_flag_o <= 1'b0;
        end
    end

    // Watchdog counter and illegal key debounce.
    // The counter never stops: clear events only restart it, so
    // a sleeping device still has its overflow wake source.
    // The debounce counts whole slow ticks; because the bad key
    // lands part way through a tick period, the reset follows
    // between two and three periods later.
    always @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            wdt_cnt_reg <= 18'h0_0000;
            sub_prev_reg <= 1'b0;
            deb_cnt_reg <= 2'd0;
        end
        else if (ce_i)
        begin
            sub_prev_reg <= sub_clock_i;
            // Clear events restart the count, which keeps running
            if (soft_rst || clear_watchdog_instruction_i || (halt_exec_i && state_reg == ST_RUN) || full_rst)
                wdt_cnt_reg <= 18'h0_0000;
            else if (sub_tick)
                wdt_cnt_reg <= cnt_inc;
            // Count ticks while key is bad; first tick partial gives 2-3
            if (!key_bad || soft_rst)
                deb_cnt_reg <= 2'd0;
            else if (sub_tick && deb_cnt_reg != `WWC_DEBOUNCE_TICKS)
                deb_cnt_reg <= deb_cnt_reg + 2'd1;
        end
    end

    // Sleep, wake and start-up sequencer.
    // Pin history is sampled on slow ticks in every state, so a
    // pin that falls before the last slow tick ahead of halt is seen as low and
    // cannot cause a false wake. Requests pending at entry are
    // disarmed; only a request that rises while asleep wakes us.
    // The outcome pulses are mutually exclusive and last one cycle.
    always @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            state_reg <= ST_RUN;
            cause_reg <= CAUSE_PIN;
            sst_cnt_reg <= 11'd0;
            pin_prev_reg <= {NPIN{1'b1}};
            irq_armed_reg <= {NIRQ{1'b0}};
            irq_wake_src_o <= {NIRQ{1'b0}};
            cpu_run_o <= 1'b1;
            asleep_o <= 1'b0;
            device_reset_o <= 1'b0;
            pc_sp_reset_o <= 1'b0;
            resume_next_o <= 1'b0;
            irq_service_o <= 1'b0;
        end
        else if (ce_i)
        begin
            device_reset_o <= full_rst;
            pc_sp_reset_o <= 1'b0;
            resume_next_o <= 1'b0;
            irq_service_o <= 1'b0;
            if (sub_tick)
                pin_prev_reg <= port_i;
            case (state_reg)
                ST_RUN:
                begin
                    // Halt enters sleep or idle; idle_select only chooses clocks
                    if (halt_exec_i && !full_rst)
                    begin
                        state_reg <= ST_SLEEP;
                        irq_armed_reg <= ~irq_req_i;
                        cpu_run_o <= 1'b0;
                        asleep_o <= 1'b1;
                    end
                end
                ST_SLEEP:
                begin
                    // Overflow has priority so the reset sequence is seen
                    if (wdt_wake || irq_wake || pin_wake || soft_rst)
                    begin
                        state_reg <= ST_START;
                        sst_cnt_reg <= 11'd0;
                        asleep_o <= 1'b0;
                        irq_wake_src_o <= irq_hit;
                        if (wdt_wake || soft_rst)
                            cause_reg <= CAUSE_WDT;
                        else if (irq_wake)
                            cause_reg <= CAUSE_IRQ;
                        else
                            cause_reg <= CAUSE_PIN;
                    end
                end
                ST_START:
                begin
                    // Count stops at the target so a slow-settling fast
                    // oscillator just holds the CPU here, no wrap hazard
                    if (!sst_done)
                        sst_cnt_reg <= sst_cnt_reg + 11'd1;
                    if (start_ok)
                    begin
                        state_reg <= ST_RUN;
                        cpu_run_o <= 1'b1;
                        case (cause_reg)
                            CAUSE_WDT: pc_sp_reset_o <= ~swr_flag_reg | ~key_bad;
                            // Serviced only if some waking source can be taken now
                            CAUSE_IRQ:
                            begin
                                if ((|(irq_wake_src_o & irq_en_i)) && !stack_full_i)
                                    irq_service_o <= 1'b1;
                                else
                                    resume_next_o <= 1'b1;
                            end
                            default: resume_next_o <= 1'b1;
                        endcase
                    end
                end
                default: state_reg <= ST_RUN;
            endcase
        end
    end

endmodule // wwc_watchdog_wake

// ### bench/wwc_watchdog_wake_chk.sv
`timescale 1ns/1ns
// Port-level checker for the watchdog and wake block
module wwc_watchdog_wake_chk (
    input wire core_clk_i, // Core clock
    input wire rst_i, // Async reset, high
    input wire ce_i, // Clock enable
    input wire psel_i, // APB select
    input wire penable_i, // APB access phase
    input wire pwrite_i, // APB write
    input wire [11:0] paddr_i, // APB address
    input wire [31:0] prdata_o, // APB read data
    input wire pready_o, // APB ready
    input wire pslverr_o, // APB error
    input wire halt_exec_i, // Stop instruction
    input wire clear_watchdog_instruction_i, // Clear instruction
    input wire sysclk_fast_i, // Fast system clock
    input wire fast_osc_stable_i, // Fast oscillator stable
    input wire cpu_run_o, // CPU may run
    input wire device_reset_o, // Full reset pulse
    input wire pc_sp_reset_o, // PC/SP reset pulse
    input wire resume_next_o, // Resume pulse
    input wire irq_service_o, // Interrupt service pulse
    input wire asleep_o, // Asleep level
    input wire power_down_flag_o // Power-down flag
);
    // One domain, so one clock and one disable for all
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    wire acc = psel_i & penable_i; // Access phase
    wire mapped = (paddr_i == 12'h000) || (paddr_i == 12'h004) || (paddr_i == 12'h008); // Known offsets
    a_ready_high: assert property (pready_o) else $error("ready dropped");
    a_unmapped_err: assert property (acc && !mapped |-> pslverr_o && prdata_o == 32'h0000_0000)
        else $error("unmapped access not refused");
    a_flags_gap: assert property (acc && !pwrite_i && paddr_i == 12'h004 |-> prdata_o[6:1] == 6'h00)
        else $error("unused flag bits read nonzero");
    a_halt_sleep: assert property (halt_exec_i && cpu_run_o && ce_i |=> asleep_o && !cpu_run_o && power_down_flag_o)
        else $error("halt did not enter sleep");
    a_clr_pdf: assert property (clear_watchdog_instruction_i && !halt_exec_i && cpu_run_o && ce_i |=> !power_down_flag_o)
        else $error("clear did not drop power-down flag");
    a_reset_pulse: assert property (device_reset_o |=> !device_reset_o)
        else $error("device reset longer than one cycle");
    a_wake_onehot: assert property ($onehot0({pc_sp_reset_o, resume_next_o, irq_service_o}))
        else $error("two wake outcomes at once");
    a_fast_hold: assert property (!asleep_o && !cpu_run_o && sysclk_fast_i && !fast_osc_stable_i |=> !cpu_run_o)
        else $error("ran before fast oscillator stable");
    a_sleep_no_reset: assert property (asleep_o |-> !device_reset_o)
        else $error("full reset while asleep");
endmodule // wwc_watchdog_wake_chk

bind wwc_watchdog_wake wwc_watchdog_wake_chk chk_u (.core_clk_i(core_clk_i), .rst_i(rst_i), .ce_i(ce_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .halt_exec_i(halt_exec_i), .clear_watchdog_instruction_i(clear_watchdog_instruction_i),
    .sysclk_fast_i(sysclk_fast_i), .fast_osc_stable_i(fast_osc_stable_i), .cpu_run_o(cpu_run_o),
    .device_reset_o(device_reset_o), .pc_sp_reset_o(pc_sp_reset_o), .resume_next_o(resume_next_o),
    .irq_service_o(irq_service_o), .asleep_o(asleep_o), .power_down_flag_o(power_down_flag_o));

// ### bench/tb_top.sv
`timescale 1ns/1ns
// Register, sleep and watchdog bench
module tb_top;
    reg clk = 1'b0; // 125 MHz core clock
    reg rst = 1'b1; // Held high at start
    reg psel = 1'b0, pen = 1'b0, pwr = 1'b0; // APB controls
    reg [11:0] paddr = 12'h000; // APB address
    reg [31:0] pwdata = 32'h0000_0000; // APB write data
    reg [1:0] sdiv = 2'b00; // Sub clock divider, a tick every four cycles
    reg [7:0] port = 8'hff, wake_en = 8'h00; // Pins idle high
    reg [3:0] irq_req = 4'h0, irq_en = 4'h0; // Interrupt side
    reg stack_full = 1'b0, halt = 1'b0, clr = 1'b0, fast = 1'b0, stable = 1'b1; // CPU side
    reg ce = 1'b1; // Clock enable
    wire [3:0] wsrc; // Waking requests
    wire keep; // Idle clock keep-on level
    wire [31:0] prdata; // Read data
    wire pready, pslverr, run, drst, pcsp, resume, svc, asleep, to_f, power_down_flag; // Outputs
    reg [31:0] rd; // Last read word
    reg err; // Last error bit
    reg [3:0] ev; // Pulses: full reset, PC/SP, resume, service
    int n_fail = 0, checked = 0, n, i;
    always #4 clk = ~clk;
    // Slow tick source, much slower than the core clock as sampling needs
    always @(posedge clk) sdiv <= sdiv + 2'd1;
    wwc_watchdog_wake #(.SST_FAST(8)) dut_u (.core_clk_i(clk), .rst_i(rst), .ce_i(ce), .psel_i(psel),
        .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .sub_clock_i(sdiv[1]), .port_i(port),
        .port_wake_enable_i(wake_en), .irq_req_i(irq_req), .irq_en_i(irq_en), .stack_full_i(stack_full),
        .halt_exec_i(halt), .idle_select_i(1'b0), .clear_watchdog_instruction_i(clr), .sysclk_fast_i(fast),
        .fast_osc_stable_i(stable), .cpu_run_o(run), .device_reset_o(drst), .pc_sp_reset_o(pcsp),
        .resume_next_o(resume), .irq_service_o(svc), .irq_wake_src_o(wsrc), .asleep_o(asleep),
        .idle_clk_keep_on_o(keep), .timeout_flag_o(to_f), .power_down_flag_o(power_down_flag));
    // Compare and count
    task chk(input [31:0] seen, input [31:0] exp);
        begin
            checked++;
            if (seen !== exp)
            begin
                n_fail++;
                $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
            end
        end
    endtask
    // One APB transfer; request held until ready is sampled
    task apb(input w, input [11:0] a, input [31:0] d);
        begin
            @(posedge clk);
            psel <= 1'b1;
            pwr <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge clk);
            pen <= 1'b1;
            @(posedge clk);
            while (pready !== 1'b1) @(posedge clk);
            rd = prdata;
            err = pslverr;
            psel <= 1'b0;
            pen <= 1'b0;
        end
    endtask
    // One-cycle instruction pulse: clear when c, else halt
    task ins(input c);
        begin
            @(posedge clk);
            if (c) clr <= 1'b1;
            else halt <= 1'b1;
            @(posedge clk);
            clr <= 1'b0;
            halt <= 1'b0;
        end
    endtask
    // Wait for any outcome pulse, bounded; n counts cycles
    task wait_ev(input int lim);
        begin
            n = 0;
            ev = 4'h0;
            while (ev == 4'h0 && n < lim)
            begin
                @(posedge clk);
                #1 ev = {drst, pcsp, resume, svc};
                n++;
            end
        end
    endtask
    // Single exit for the run
    task results;
        begin
            $display("checks=%0d mismatches=%0d", checked, n_fail);
            if (n_fail == 0 && checked > 0) $display("[ PASS ]");
            else $display("[ FAIL ]");
            $finish;
        end
    endtask
    // Hang guard, several times the expected run
    initial
    begin
        repeat (20000) @(posedge clk);
        n_fail++;
        results;
    end
    initial
    begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        apb(0, 12'h000, 0); chk(rd, 32'h0000_0053);
        apb(0, 12'h008, 0); chk(rd, 32'h0000_0000);
        apb(0, 12'h00c, 0); chk(err, 1);
        // Write with clock enable low must not land
        ce <= 1'b0; apb(1, 12'h004, 32'h0000_0080); ce <= 1'b1;
        apb(0, 12'h004, 0); chk(rd, 32'h0000_0000); chk(keep, 0);
        apb(1, 12'h004, 32'h0000_00ff); apb(0, 12'h004, 0); chk(rd, 32'h0000_0080);
        chk(keep, 1);
        // Pin wake on slow clock
        wake_en <= 8'h01; ins(0); repeat (4) @(posedge clk); chk(asleep, 1);
        apb(0, 12'h008, 0); chk(rd[1:0], 2'b10);
        chk(power_down_flag, 1); chk(to_f, 0);
        port <= 8'hfe; wait_ev(200); chk(ev, 4'h2);
        port <= 8'hff;
        // Unenabled pin and stale request must not wake; fast clock waits for stable
        wake_en <= 8'h02; irq_req <= 4'h8; irq_en <= 4'h8; ins(0);
        port <= 8'hfe; wait_ev(200); chk(ev, 4'h0);
        fast <= 1'b1; stable <= 1'b0; port <= 8'hfc; repeat (60) @(posedge clk); chk(run, 0);
        stable <= 1'b1; wait_ev(100); chk(ev, 4'h2);
        irq_req <= 4'h0; port <= 8'hff; fast <= 1'b0;
        // Interrupt wake: disabled, stack full, serviced
        for (i = 0; i < 3; i++)
        begin
            ins(0); repeat (4) @(posedge clk);
            irq_en <= (i == 0) ? 4'h0 : 4'h2; stack_full <= (i == 1); irq_req <= 4'h2;
            wait_ev(200); chk(ev, (i == 2) ? 4'h1 : 4'h2);
            chk(wsrc, 4'h2);
            irq_req <= 4'h0;
        end
        ins(1); apb(0, 12'h008, 0); chk(rd[1], 0); chk(power_down_flag, 0);
        // Awake timeout at shortest period
        apb(1, 12'h000, 32'h0000_00a8); ins(1); wait_ev(1200); chk(ev, 4'h8);
        chk(n >= 1012 && n <= 1032, 1);
        apb(0, 12'h008, 0); chk(rd[0], 1);
        chk(to_f, 1);
        apb(0, 12'h000, 0); chk(rd, 32'h0000_0053);
        // Asleep timeout resets only PC and SP
        apb(1, 12'h000, 32'h0000_0050); ins(0); wait_ev(1300); chk(ev, 4'h4);
        apb(0, 12'h008, 0); chk(rd[1:0], 2'b11);
        chk(to_f, 1); chk(power_down_flag, 1);
        // Bad key gives soft reset and flag
        apb(1, 12'h000, 0); wait_ev(40); chk(ev, 4'h8);
        apb(0, 12'h004, 0); chk(rd[0], 1);
        apb(0, 12'h000, 0); chk(rd, 32'h0000_0053);
        apb(1, 12'h004, 0); apb(0, 12'h004, 0); chk(rd, 32'h0000_0000);
        results;
    end
endmodule // tb_top
